// ===== shared/ssi_map.vh
// How it works
// - Parameters pick which function each input and output terminal carries; defaults after reset.
// - Both overtravel inputs start disabled; parameter digits can enable each one.
// - Enabled overtravel input permits motion its direction only while asserted.
// - Overtravel stop uses the method chosen by two stop-method digits.
// - Overtravel prohibition alone never raises the alarm output.
// - In position mode the position loop is suspended during overtravel stop.
// - In torque mode only the first stop-method digit selects the stop.
// - Homing slowdown function comes from digit zero of latch homing parameter.
// - Slowdown switch asserted during search changes speed to approach speed one.
// - Slowdown switch released after assertion switches search to latch operation.
// - Latch trigger assertion captures the feedback pulse counter.
// - Three latch triggers are assigned by digits one to three of that parameter.
`ifndef SSI_MAP_VH
`define SSI_MAP_VH
`define SSI_ADDR_IN_A 4'h0
`define SSI_ADDR_IN_B 4'h1
`define SSI_ADDR_LATCH 4'h2
`define SSI_ADDR_OUT_F 4'h3
`define SSI_ADDR_OUT_L 4'h4
`define SSI_ADDR_STOP 4'h5
`define SSI_ADDR_SPEED 4'h6
`define SSI_ADDR_CTRL 4'h7
`define SSI_ADDR_STAT 4'h8
`define SSI_ADDR_CAP1 4'h9
`define SSI_ADDR_CAP2 4'ha
`define SSI_ADDR_CAP3 4'hb
`define SSI_RST_IN_A 16'h8100
`define SSI_RST_IN_B 16'h6548
`define SSI_RST_LATCH 16'h6543
`define SSI_RST_OUT_F 16'h0000
`define SSI_RST_OUT_L 16'h0100
`define SSI_RST_STOP 16'h0000
`define SSI_RST_SPEED 16'h0000
`define SSI_DIG_DISABLE 4'h8
`define SSI_DIG_ENABLE 4'h7
`define SSI_MODE_POS 2'h0
`define SSI_MODE_SPD 2'h1
`define SSI_MODE_TRQ 2'h2
`endif

// ===== hdl/ssi_seq_inputs.v
`include "ssi_map.vh"
module ssi_seq_inputs #(
  parameter CNT_W = 32
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Input terminals SI0 to SI6, asynchronous
  input wire [6:0] seq_in_pins,
  // Drive state from the control core
  input wire [CNT_W-1:0] feedback_count,
  input wire motion_fwd_req,
  input wire motion_rev_req,
  input wire drive_fault,
  input wire brake_release,
  input wire homing_start,
  // Results
  output reg forward_travel_block,
  output reg reverse_travel_block,
  output reg [1:0] stop_action,
  output reg position_loop_hold,
  output reg servo_lock_flag,
  output reg homing_slow,
  output reg homing_latch_arm,
  output reg [15:0] approach_speed,
  output reg servo_alarm_out,
  output reg brake_interlock_out,
  output reg [2:0] out_terminals
);
  reg [15:0] input_assign_param_a_r;
  reg [15:0] input_assign_param_b_r;
  reg [15:0] latch_homing_assign_param_r;
  reg [15:0] output_assign_param_first_r;
  reg [15:0] output_assign_param_last_r;
  reg [15:0] stop_method_param_r;
  reg [15:0] origin_approach_speed_one_r;
  reg [1:0] ctrl_mode_r;
  reg [6:0] sync1_r;
  reg [6:0] sync2_r;
  reg [6:0] prev_r;
  reg [2:0] cap_flag_r;
  reg [CNT_W-1:0] cap_r [0:2];
  reg [1:0] home_st_r;
  reg [1:0] home_st_nxt;
  reg [1:0] stop_nxt;
  // Origin search: fast, slow while the slowdown switch holds, then wait for a latch.
  localparam HOME_IDLE = 2'h0;
  localparam HOME_FAST = 2'h1;
  localparam HOME_SLOW = 2'h2;
  localparam HOME_LATCH = 2'h3;
  // Digit decode: 0..6 selects terminal, 7 always on, 8 never on.
  function pick;
    input [3:0] dig;
    input [6:0] lvl;
    begin
      if (dig == `SSI_DIG_ENABLE)
        pick = 1'b1;
      else if (dig < 4'h7)
        pick = lvl[dig[2:0]];
      else
        pick = 1'b0;
    end
  endfunction
  // Output digit: 0 none, 1..3 drives terminal SO1..SO3.
  function [2:0] route;
    input [3:0] dig;
    input src;
    begin
      route = 3'h0;
      if (dig >= 4'h1 && dig <= 4'h3)
        route[dig[1:0] - 2'h1] = src;
    end
  endfunction
  // Overtravel digit: a disabled input (digit 8) leaves its direction permitted.
  function permit;
    input [3:0] dig;
    input [6:0] lvl;
    begin
      if (dig == `SSI_DIG_DISABLE)
        permit = 1'b1;
      else
        permit = pick(dig, lvl);
    end
  endfunction
  // Rising edge of the selected function; a fixed level never makes an edge, so a
  // trigger tied on by digit 7 cannot capture on every clock.
  function rose;
    input [3:0] dig;
    input [6:0] now;
    input [6:0] old;
    begin
      rose = pick(dig, now) & ~pick(dig, old);
    end
  endfunction
  wire fwd_ok = permit(input_assign_param_a_r[15:12], sync2_r);
  wire rev_ok = permit(input_assign_param_b_r[3:0], sync2_r);
  wire dec_lvl = pick(latch_homing_assign_param_r[3:0], sync2_r);
  wire dec_prev = pick(latch_homing_assign_param_r[3:0], prev_r);
  wire [2:0] ext_up;
  assign ext_up[0] = rose(latch_homing_assign_param_r[7:4], sync2_r, prev_r);
  assign ext_up[1] = rose(latch_homing_assign_param_r[11:8], sync2_r, prev_r);
  assign ext_up[2] = rose(latch_homing_assign_param_r[15:12], sync2_r, prev_r);
  // A read of a capture word clears its flag.
  wire [2:0] cap_clr;
  assign cap_clr[0] = reg_rd && reg_addr == `SSI_ADDR_CAP1;
  assign cap_clr[1] = reg_rd && reg_addr == `SSI_ADDR_CAP2;
  assign cap_clr[2] = reg_rd && reg_addr == `SSI_ADDR_CAP3;
  wire fwd_blk = ~fwd_ok & motion_fwd_req;
  wire rev_blk = ~rev_ok & motion_rev_req;
  wire any_blk = fwd_blk | rev_blk;
  // Two flip-flops bring the terminals into the clock domain; prev_r holds the last level.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      prev_r <= 7'h00;
    end
    else
    begin
      sync1_r <= seq_in_pins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  // Register writes; defaults restored by reset.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      input_assign_param_a_r <= `SSI_RST_IN_A;
      input_assign_param_b_r <= `SSI_RST_IN_B;
      latch_homing_assign_param_r <= `SSI_RST_LATCH;
      output_assign_param_first_r <= `SSI_RST_OUT_F;
      output_assign_param_last_r <= `SSI_RST_OUT_L;
      stop_method_param_r <= `SSI_RST_STOP;
      origin_approach_speed_one_r <= `SSI_RST_SPEED;
      ctrl_mode_r <= `SSI_MODE_POS;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SSI_ADDR_IN_A: input_assign_param_a_r <= reg_wdata;
        `SSI_ADDR_IN_B: input_assign_param_b_r <= reg_wdata;
        `SSI_ADDR_LATCH: latch_homing_assign_param_r <= reg_wdata;
        `SSI_ADDR_OUT_F: output_assign_param_first_r <= reg_wdata;
        `SSI_ADDR_OUT_L: output_assign_param_last_r <= reg_wdata;
        `SSI_ADDR_STOP: stop_method_param_r <= reg_wdata;
        `SSI_ADDR_SPEED: origin_approach_speed_one_r <= reg_wdata;
        `SSI_ADDR_CTRL: ctrl_mode_r <= reg_wdata[1:0];
        // Writes to the status and capture words are ignored.
        default: ctrl_mode_r <= ctrl_mode_r;
      endcase
    end
  end
  // Capture; a read of a capture word clears its flag, a new capture wins.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      cap_flag_r <= 3'h0;
      cap_r[0] <= {CNT_W{1'b0}};
      cap_r[1] <= {CNT_W{1'b0}};
      cap_r[2] <= {CNT_W{1'b0}};
    end
    else
    begin
      if (ext_up[0])
        cap_r[0] <= feedback_count;
      if (ext_up[1])
        cap_r[1] <= feedback_count;
      if (ext_up[2])
        cap_r[2] <= feedback_count;
      cap_flag_r <= (cap_flag_r & ~cap_clr) | ext_up;
    end
  end
  // A start request while a search runs is ignored.
  always @*
  begin
    home_st_nxt = home_st_r;
    case (home_st_r)
      HOME_IDLE:
        if (homing_start)
          home_st_nxt = HOME_FAST;
      HOME_FAST:
        if (dec_lvl)
          home_st_nxt = HOME_SLOW;
      HOME_SLOW:
        if (!dec_lvl && dec_prev)
          home_st_nxt = HOME_LATCH;
      HOME_LATCH:
        if (ext_up[0])
          home_st_nxt = HOME_IDLE;
      default: home_st_nxt = HOME_IDLE;
    endcase
  end
  always @(posedge sys_clk)
  begin
    if (reset)
      home_st_r <= HOME_IDLE;
    else
      home_st_r <= home_st_nxt;
  end
  // Stop method for a blocked request; torque mode ignores the second digit.
  always @*
  begin
    if (!any_blk)
      stop_nxt = 2'h0;
    else if (ctrl_mode_r == `SSI_MODE_TRQ)
      stop_nxt = {1'b0, stop_method_param_r[0]};
    else
      stop_nxt = {stop_method_param_r[4], stop_method_param_r[0]};
  end
  // Overtravel results, all from flip-flops.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      forward_travel_block <= 1'b0;
      reverse_travel_block <= 1'b0;
      stop_action <= 2'h0;
      position_loop_hold <= 1'b0;
      servo_lock_flag <= 1'b0;
    end
    else
    begin
      forward_travel_block <= fwd_blk;
      reverse_travel_block <= rev_blk;
      stop_action <= stop_nxt;
      position_loop_hold <= any_blk && ctrl_mode_r == `SSI_MODE_POS;
      // Servo lock is held only when the whole second stop digit asks for it.
      servo_lock_flag <= any_blk && ctrl_mode_r != `SSI_MODE_TRQ
        && stop_method_param_r[7:4] == 4'h1;
    end
  end
  // Homing flags follow the next state so they line up with the state register.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      homing_slow <= 1'b0;
      homing_latch_arm <= 1'b0;
      approach_speed <= 16'h0000;
    end
    else
    begin
      homing_slow <= home_st_nxt == HOME_SLOW;
      homing_latch_arm <= home_st_nxt == HOME_LATCH;
      approach_speed <= origin_approach_speed_one_r;
    end
  end
  // Alarm, brake and terminal routing; an overtravel block never reaches the alarm.
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      servo_alarm_out <= 1'b0;
      brake_interlock_out <= 1'b0;
      out_terminals <= 3'h0;
    end
    else
    begin
      servo_alarm_out <= ~drive_fault;
      brake_interlock_out <= brake_release;
      out_terminals <= route(output_assign_param_last_r[11:8], brake_release)
        | route(output_assign_param_first_r[3:0], ~drive_fault);
    end
  end
  // Read data one cycle after the strobe.
  always @(posedge sys_clk)
  begin
    if (reset)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SSI_ADDR_IN_A: reg_rdata <= input_assign_param_a_r;
        `SSI_ADDR_IN_B: reg_rdata <= input_assign_param_b_r;
        `SSI_ADDR_LATCH: reg_rdata <= latch_homing_assign_param_r;
        `SSI_ADDR_OUT_F: reg_rdata <= output_assign_param_first_r;
        `SSI_ADDR_OUT_L: reg_rdata <= output_assign_param_last_r;
        `SSI_ADDR_STOP: reg_rdata <= stop_method_param_r;
        `SSI_ADDR_SPEED: reg_rdata <= origin_approach_speed_one_r;
        `SSI_ADDR_CTRL: reg_rdata <= {14'h0000, ctrl_mode_r};
        `SSI_ADDR_STAT: reg_rdata <= {4'h0, cap_flag_r, home_st_r, sync2_r};
        // Capture words return only the low half of the counter.
        `SSI_ADDR_CAP1: reg_rdata <= cap_r[0][15:0];
        `SSI_ADDR_CAP2: reg_rdata <= cap_r[1][15:0];
        `SSI_ADDR_CAP3: reg_rdata <= cap_r[2][15:0];
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end
endmodule

// ===== sim/ssi_properties.sv
module ssi_chk (
  // Watched ports of the sequence-input block.
  input wire sys_clk,
  input wire reset,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [6:0] seq_in_pins,
  input wire motion_fwd_req,
  input wire motion_rev_req,
  input wire drive_fault,
  input wire forward_travel_block,
  input wire reverse_travel_block,
  input wire [1:0] stop_action,
  input wire position_loop_hold,
  input wire servo_lock_flag,
  input wire homing_slow,
  input wire homing_latch_arm,
  input wire servo_alarm_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  alarm_tracks_fault_a:
  assert property (!$past(reset) |-> servo_alarm_out == !$past(drive_fault))
    else $error("alarm output does not follow the fault input");
  fwd_needs_req_a:
  assert property (!$past(motion_fwd_req) |-> !forward_travel_block)
    else $error("forward block without a forward request");
  rev_needs_req_a:
  assert property (!$past(motion_rev_req) |-> !reverse_travel_block)
    else $error("reverse block without a reverse request");
  stop_only_blocked_a:
  assert property (stop_action != 2'h0 |-> forward_travel_block || reverse_travel_block)
    else $error("stop action while nothing is blocked");
  loop_hold_block_a:
  assert property (position_loop_hold |-> forward_travel_block || reverse_travel_block)
    else $error("position loop held without a block");
  lock_second_digit_a:
  assert property (servo_lock_flag |-> stop_action[1])
    else $error("servo lock without the second stop digit");
  slow_from_switch_a:
  assert property ($rose(homing_slow) |-> $past(seq_in_pins[3], 3))
    else $error("slow approach without the slowdown switch");
  latch_after_slow_a:
  assert property ($rose(homing_latch_arm) |-> $past(homing_slow) && !$past(seq_in_pins[3], 3))
    else $error("latch armed without slowdown release");
  rdata_idle_zero_a:
  assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
endmodule
bind ssi_seq_inputs ssi_chk u_ssi_chk (.sys_clk, .reset, .reg_rd, .reg_rdata, .seq_in_pins,
  .motion_fwd_req, .motion_rev_req, .drive_fault, .forward_travel_block, .reverse_travel_block,
  .stop_action, .position_loop_hold, .servo_lock_flag, .homing_slow, .homing_latch_arm,
  .servo_alarm_out);

// ===== sim/ssi_field.sv
module ssi_field (
  // Clock.
  input wire sys_clk,
  // Switch states asked for by the bench.
  input wire fwd_ok,
  input wire rev_ok,
  input wire slow_sw,
  input wire [2:0] trig,
  // Terminal levels.
  output logic [6:0] seq_in_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial seq_in_pins = 7'h00;
  always @(posedge sys_clk)
  begin
    seq_in_pins <= {trig, slow_sw, rev_ok, fwd_ok, 1'h0};
  end
endmodule

// ===== sim/tb.sv
`include "ssi_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0, reg_rd = 1'h0, motion_fwd_req = 1'h0, motion_rev_req = 1'h0;
  logic drive_fault = 1'h0, brake_release = 1'h0, homing_start = 1'h0;
  logic fwd_ok = 1'h0, rev_ok = 1'h0, slow_sw = 1'h0, ef, er, b;
  logic [2:0] trig = 3'h0;
  logic [31:0] feedback_count = 32'h0, cnt;
  logic [15:0] st, sp;
  logic [1:0] md;
  logic [15:0] dflt [0:6] = '{`SSI_RST_IN_A, `SSI_RST_IN_B, `SSI_RST_LATCH, `SSI_RST_OUT_F,
    `SSI_RST_OUT_L, `SSI_RST_STOP, `SSI_RST_SPEED};
  wire [15:0] reg_rdata, approach_speed;
  wire [6:0] seq_in_pins;
  wire [1:0] stop_action;
  wire forward_travel_block, reverse_travel_block, position_loop_hold, servo_lock_flag;
  wire homing_slow, homing_latch_arm, servo_alarm_out, brake_interlock_out;
  wire [2:0] out_terminals;
  integer seed = 29, mismatches = 0, checked = 0, cycles = 0, i;
  logic [15:0] exp_cap[$];
  ssi_seq_inputs u_ssi_seq_inputs (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .seq_in_pins, .feedback_count, .motion_fwd_req, .motion_rev_req, .drive_fault,
    .brake_release, .homing_start, .forward_travel_block, .reverse_travel_block, .stop_action,
    .position_loop_hold, .servo_lock_flag, .homing_slow, .homing_latch_arm, .approach_speed,
    .servo_alarm_out, .brake_interlock_out, .out_terminals);
  ssi_field u_ssi_field (.sys_clk, .fwd_ok, .rev_ok, .slow_sw, .trig, .seq_in_pins);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      mismatches = mismatches + 1;
      test_done;
    end
  end
  task test_done;
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
  endtask
  task settle;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'h0;
    for (i = 0; i < 7; i++)
      rd(i[3:0], dflt[i]);
    rd(4'hc, 16'h0000);
    @(posedge sys_clk);
    {motion_fwd_req, motion_rev_req} <= 2'h3;
    settle;
    chk("fwd_dflt", 0, forward_travel_block);
    chk("rev_dflt", 0, reverse_travel_block);
    wr(`SSI_ADDR_IN_A, 16'h1100);
    wr(`SSI_ADDR_IN_B, 16'h6542);
    sp = 16'($random(seed));
    wr(`SSI_ADDR_SPEED, sp);
    wr(`SSI_ADDR_OUT_F, 16'h0002);
    for (i = 0; i < 48; i++)
    begin
      md = 2'(i % 3);
      st = 16'($random(seed)) & 16'h0011;
      wr(`SSI_ADDR_CTRL, {14'h0, md});
      wr(`SSI_ADDR_STOP, st);
      cnt = $random(seed);
      {fwd_ok, rev_ok, motion_fwd_req, motion_rev_req, drive_fault, brake_release} <= cnt[5:0];
      settle;
      ef = motion_fwd_req & ~fwd_ok;
      er = motion_rev_req & ~rev_ok;
      b = ef | er;
      chk("fwd_blk", ef, forward_travel_block);
      chk("rev_blk", er, reverse_travel_block);
      chk("stop", !b ? 0 : md == 2'h2 ? st[0] : {st[4], st[0]}, stop_action);
      chk("hold", b && md == 2'h0, position_loop_hold);
      chk("lock", b && md != 2'h2 && st[4], servo_lock_flag);
      chk("alarm", !drive_fault, servo_alarm_out);
      chk("brake", brake_release, brake_interlock_out);
      chk("terms", {1'b0, !drive_fault, brake_release}, out_terminals);
    end
    for (i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      cnt = $random(seed);
      feedback_count <= cnt;
      exp_cap.push_back(cnt[15:0]);
      trig[i] <= 1'h1;
      settle;
      @(posedge sys_clk);
      feedback_count <= ~cnt;
      settle;
      @(posedge sys_clk);
      trig[i] <= 1'h0;
    end
    for (i = 0; i < 3; i++)
      rd(4'h9 + i[3:0], exp_cap.pop_front());
    @(posedge sys_clk);
    homing_start <= 1'h1;
    @(posedge sys_clk);
    homing_start <= 1'h0;
    slow_sw <= 1'h1;
    settle;
    chk("slow", 1, homing_slow);
    chk("speed", sp, approach_speed);
    @(posedge sys_clk);
    slow_sw <= 1'h0;
    settle;
    chk("latch", 2'h1, {homing_slow, homing_latch_arm});
    @(posedge sys_clk);
    trig <= 3'h1;
    settle;
    chk("idle", 2'h0, {homing_slow, homing_latch_arm});
    test_done;
  end
endmodule
